/* design/ette_pkg.sv */
package ette_pkg;

	// Register byte offsets
	localparam logic [7:0] ETTE_OFS_CTRL = 8'h00;
	localparam logic [7:0] ETTE_OFS_VBR  = 8'h04;
	localparam logic [7:0] ETTE_OFS_ENA  = 8'h08;
	localparam logic [7:0] ETTE_OFS_STAT = 8'h0c;

	// Control register fields
	localparam int ETTE_CTRL_SKIP   = 0;
	localparam int ETTE_CTRL_STOP   = 1;
	localparam int ETTE_CTRL_SHORT  = 2;
	localparam int ETTE_CTRL_PRIO   = 3;
	localparam int ETTE_CTRL_REL_LO = 4;
	localparam int ETTE_CTRL_W      = 7;

	localparam logic [6:0]  ETTE_CTRL_RST = 7'h00;
	localparam logic [31:0] ETTE_VBR_RST  = 32'h0000_0000;

	// Descriptor mode word fields
	localparam int ETTE_MD_LO    = 0;
	localparam int ETTE_SZ_LO    = 2;
	localparam int ETTE_SM_LO    = 4;
	localparam int ETTE_DM_LO    = 6;
	localparam int ETTE_CHNE     = 8;
	localparam int ETTE_DISEL    = 9;

	localparam logic [1:0] ETTE_MD_NORMAL = 2'h0;
	localparam logic [1:0] ETTE_MD_REPEAT = 2'h1;
	localparam logic [1:0] ETTE_MD_BLOCK  = 2'h2;

	localparam logic [1:0] ETTE_SZ_BYTE = 2'h0;
	localparam logic [1:0] ETTE_SZ_WORD = 2'h1;
	localparam logic [1:0] ETTE_SZ_LONG = 2'h2;

	localparam logic [1:0] ETTE_AM_INC = 2'h2;
	localparam logic [1:0] ETTE_AM_DEC = 2'h3;

	// Bus release policies
	localparam logic [2:0] ETTE_REL_NONE  = 3'h0;
	localparam logic [2:0] ETTE_REL_UNIT  = 3'h1;
	localparam logic [2:0] ETTE_REL_DESC  = 3'h2;
	localparam logic [2:0] ETTE_REL_ACC   = 3'h3;
	localparam logic [2:0] ETTE_REL_FETCH = 3'h4;

	localparam logic [31:0] ETTE_DESC_BYTES = 32'h0000_0010;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} ette_mreq_t;

	typedef struct packed {
		logic        ready;
		logic [31:0] rdata;
	} ette_mrsp_t;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_VEC  = 7'h02,
		S_DRD  = 7'h04,
		S_XRD  = 7'h08,
		S_XWR  = 7'h10,
		S_DWB  = 7'h20,
		S_GAP  = 7'h40
	} ette_state_t;

endpackage

/* design/ette_top.sv */
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
// Contract
// - Normal, repeat and block modes per descriptor
// - Fetch descriptor first, then move data
// - Write updated descriptor back to same place
// - Normal mode count 1 to 65536
// - Repeat mode count 1 to 256
// - Block mode block count 1 to 65536
// - Datum size byte, word or longword
// - Optional interrupt after every unit
// - Otherwise interrupt only when count exhausted
// - Chaining runs successive descriptors per activation
// - Optional skip of descriptor re-read
// - Five selectable bus release policies
// - Two selectable activation priority schemes
// - Short address mode and module stop
// - Vector entry per source gives descriptor address
// - Example channels: normal mode, 32 bytes; the receive channel in the test moves 4 bytes
// - Transmit channel: source increments, destination fixed
// - Receive channel: source fixed, destination increments
// - Example passes interrupt only after count done; the receive channel in the test interrupts after every unit
module ette_top import ette_pkg::*; #(
	parameter int NSRC = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output      logic [31:0]       prdata,
	output      logic              pready,
	output      logic              pslverr,
	output      ette_mreq_t        mreq,
	input  wire ette_mrsp_t        mrsp,
	input  wire logic [NSRC-1:0]   act_req,
	output      logic [NSRC-1:0]   cpu_irq
);

	localparam int SW = $clog2(NSRC);

	typedef struct packed {
		ette_state_t            st;
		ette_state_t            ret;
		logic [ETTE_CTRL_W-1:0] ctrl;
		logic [31:0]            vbr;
		logic [NSRC-1:0]        ena;
		logic [NSRC-1:0]        pend;
		logic [NSRC-1:0]        irq;
		logic [SW-1:0]          src;
		logic [SW-1:0]          last_src;
		logic [SW-1:0]          rr;
		logic                   dvalid;
		logic                   chained;
		logic [31:0]            daddr;
		logic [1:0]             widx;
		logic [31:0]            mode;
		logic [31:0]            sar;
		logic [31:0]            dar;
		logic [31:0]            cnt;
		logic [31:0]            data;
		logic [7:0]             blk;
		ette_mreq_t             mreq;
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
	} ette_st_t;

	localparam ette_st_t ST_RST = '{st: S_IDLE, ret: S_IDLE, ctrl: ETTE_CTRL_RST,
		vbr: ETTE_VBR_RST, default: '0};

	ette_st_t s;
	ette_st_t n;

	function automatic logic [31:0] amap(input logic sh, input logic [31:0] a);
		// Short mode reaches the top and bottom 8 MB only
		return sh ? {{8{a[23]}}, a[23:0]} : a;
	endfunction

	function automatic logic [31:0] step(input logic [1:0] am, input logic [1:0] sz,
			input logic [31:0] a);
		logic [31:0] d;
		d = 32'h1 << sz;
		if (am == ETTE_AM_INC)
			return a + d;
		if (am == ETTE_AM_DEC)
			return a - d;
		return a;
	endfunction

	function automatic logic rel_gap(input logic [2:0] p, input logic unit,
			input logic desc, input logic fetch);
		return (p == ETTE_REL_ACC) || (p == ETTE_REL_UNIT && unit) ||
			(p == ETTE_REL_DESC && desc) || (p == ETTE_REL_FETCH && fetch);
	endfunction

	function automatic logic [SW-1:0] pick(input logic [NSRC-1:0] p, input logic [SW-1:0] base);
		logic [SW-1:0] k;
		pick = base;
		for (int i = NSRC - 1; i >= 0; i--) begin
			k = SW'((int'(base) + i) % NSRC);
			if (p[k])
				pick = k;
		end
	endfunction

	function automatic ette_mreq_t acc(input logic wr, input logic [1:0] sz,
			input logic [31:0] a, input logic [31:0] d);
		return '{valid: 1'b1, write: wr, size: sz, addr: a, wdata: d};
	endfunction

	logic              mdone;
	logic              go_en;
	ette_state_t       go_st;
	logic              p_unit;
	logic              p_desc;
	logic              p_fetch;
	logic              fin;
	logic              sh;
	logic [1:0]        md;
	logic [1:0]        sz;
	logic [SW-1:0]     idx;
	logic [NSRC-1:0]   clr;
	logic [31:0]       wb;

	always_comb begin
		n = s;
		go_en = 1'b0;
		go_st = S_IDLE;
		p_unit = 1'b0;
		p_desc = 1'b0;
		p_fetch = 1'b0;
		fin = 1'b0;
		clr = '0;
		wb = s.mode;
		idx = pick(s.pend, s.ctrl[ETTE_CTRL_PRIO] ? s.rr : '0);
		sh = s.ctrl[ETTE_CTRL_SHORT];
		md = s.mode[ETTE_MD_LO +: 2];
		sz = s.mode[ETTE_SZ_LO +: 2];
		mdone = s.mreq.valid & mrsp.ready;
		n.irq = '0;
		if (mdone)
			n.mreq.valid = 1'b0;

		unique case (s.st)
			S_IDLE: begin
				n.chained = 1'b0;
				if (!s.ctrl[ETTE_CTRL_STOP] && |s.pend) begin
					n.src = idx;
					clr[idx] = 1'b1;
					n.rr = (int'(idx) == NSRC - 1) ? '0 : SW'(idx + 1'b1);
					n.blk = s.cnt[7:0];
					if (s.ctrl[ETTE_CTRL_SKIP] && s.dvalid && idx == s.last_src)
						n.st = S_XRD;
					else begin
						n.dvalid = 1'b0;
						n.st = S_VEC;
					end
				end
			end
			S_VEC: begin
				if (!s.mreq.valid)
					n.mreq = acc(1'b0, ETTE_SZ_LONG, amap(sh, s.vbr + 32'({s.src, 2'b00})),
						'0);
				else if (mdone) begin
					n.daddr = amap(sh, mrsp.rdata);
					n.widx = 2'h0;
					go_en = 1'b1;
					go_st = S_DRD;
				end
			end
			S_DRD: begin
				if (!s.mreq.valid)
					n.mreq = acc(1'b0, ETTE_SZ_LONG, s.daddr + 32'({s.widx, 2'b00}), '0);
				else if (mdone) begin
					unique case (s.widx)
						2'h0: n.mode = mrsp.rdata;
						2'h1: n.sar = mrsp.rdata;
						2'h2: n.dar = mrsp.rdata;
						2'h3: n.cnt = mrsp.rdata;
					endcase
					n.widx = s.widx + 2'h1;
					n.blk = mrsp.rdata[7:0];
					go_en = 1'b1;
					go_st = (s.widx == 2'h3) ? S_XRD : S_DRD;
					p_fetch = (s.widx == 2'h3);
				end
			end
			S_XRD: begin
				if (!s.mreq.valid)
					n.mreq = acc(1'b0, sz, amap(sh, s.sar), '0);
				else if (mdone) begin
					n.data = mrsp.rdata;
					go_en = 1'b1;
					go_st = S_XWR;
				end
			end
			S_XWR: begin
				if (!s.mreq.valid)
					n.mreq = acc(1'b1, sz, amap(sh, s.dar), s.data);
				else if (mdone) begin
					n.sar = step(s.mode[ETTE_SM_LO +: 2], sz, s.sar);
					n.dar = step(s.mode[ETTE_DM_LO +: 2], sz, s.dar);
					go_en = 1'b1;
					if (md == ETTE_MD_BLOCK && s.blk != 8'h01) begin
						// Block size 0 wraps through 255, giving 256
						n.blk = s.blk - 8'h01;
						go_st = S_XRD;
					end else begin
						unique case (md)
							ETTE_MD_REPEAT: begin
								// Repeat reloads and never completes
								n.cnt[7:0] = (s.cnt[7:0] == 8'h01) ? s.cnt[15:8] :
									s.cnt[7:0] - 8'h01;
							end
							ETTE_MD_BLOCK: begin
								n.cnt[31:16] = s.cnt[31:16] - 16'h0001;
								fin = (s.cnt[31:16] == 16'h0001);
							end
							default: begin
								n.cnt[15:0] = s.cnt[15:0] - 16'h0001;
								fin = (s.cnt[15:0] == 16'h0001);
							end
						endcase
						if (fin || s.mode[ETTE_DISEL])
							n.irq[s.src] = 1'b1;
						if (fin)
							n.ena[s.src] = 1'b0;
						n.widx = 2'h1;
						go_st = S_DWB;
						p_unit = 1'b1;
					end
				end
			end
			S_DWB: begin
				unique case (s.widx)
					2'h1: wb = s.sar;
					2'h2: wb = s.dar;
					2'h3: wb = s.cnt;
					default: wb = s.mode;
				endcase
				if (!s.mreq.valid)
					n.mreq = acc(1'b1, ETTE_SZ_LONG, s.daddr + 32'({s.widx, 2'b00}), wb);
				else if (mdone) begin
					go_en = 1'b1;
					go_st = S_DWB;
					n.widx = s.widx + 2'h1;
					if (s.widx == 2'h3) begin
						p_desc = 1'b1;
						n.last_src = s.src;
						// A chained copy is not the source's first descriptor
						n.dvalid = !s.chained && !s.mode[ETTE_CHNE];
						if (s.mode[ETTE_CHNE]) begin
							n.daddr = s.daddr + ETTE_DESC_BYTES;
							n.widx = 2'h0;
							n.chained = 1'b1;
							go_st = S_DRD;
						end else
							go_st = S_IDLE;
					end
				end
			end
			S_GAP: n.st = s.ret;
			default: n.st = S_IDLE;
		endcase

		if (go_en) begin
			if (rel_gap(s.ctrl[ETTE_CTRL_REL_LO +: 3], p_unit, p_desc, p_fetch)) begin
				n.st = S_GAP;
				n.ret = go_st;
			end else
				n.st = go_st;
		end

		// New requests win over the service clear
		n.pend = (s.pend & ~clr) | (act_req & s.ena);

		n.pready = psel & ~penable;
		n.pslverr = 1'b0;
		n.prdata = '0;
		if (psel && !penable) begin
			unique case (paddr)
				ETTE_OFS_CTRL: n.prdata = 32'(s.ctrl);
				ETTE_OFS_VBR:  n.prdata = s.vbr;
				ETTE_OFS_ENA:  n.prdata = 32'(s.ena);
				ETTE_OFS_STAT: n.prdata = 32'({s.pend, s.src, s.dvalid, s.st != S_IDLE});
				default:       n.pslverr = 1'b1;
			endcase
			if (pwrite)
				n.prdata = '0;
		end
		// Software write lands after the hardware clear, so it wins
		if (psel && penable && s.pready && pwrite) begin
			unique case (paddr)
				ETTE_OFS_CTRL: n.ctrl = pwdata[ETTE_CTRL_W-1:0];
				ETTE_OFS_VBR:  n.vbr = pwdata;
				ETTE_OFS_ENA:  n.ena = pwdata[NSRC-1:0];
				default:       n.ctrl = n.ctrl;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s <= ST_RST;
		else
			s <= n;
	end

	assign prdata  = s.prdata;
	assign pready  = s.pready;
	assign pslverr = s.pslverr;
	assign mreq    = s.mreq;
	assign cpu_irq = s.irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_MREQ_HOLD: assert property (
		s.mreq.valid && !mrsp.ready |=> s.mreq.valid && $stable(s.mreq.addr)
	) else $error("Memory request dropped or changed before ready");

	AST_WB_AFTER_DATA: assert property (
		s.st == S_DWB && $past(s.st) != S_DWB |->
			$past(s.st) == S_XWR || $past(s.st) == S_GAP
	) else $error("Descriptor write-back not preceded by data write");

	AST_WB_ADDR: assert property (
		s.st == S_DWB && s.mreq.valid |->
			s.mreq.write && s.mreq.addr == s.daddr + 32'({s.widx, 2'b00})
	) else $error("Write-back address differs from descriptor location");

	AST_VEC_ADDR: assert property (
		s.st == S_VEC && s.mreq.valid && !s.ctrl[ETTE_CTRL_SHORT] |->
			!s.mreq.write && s.mreq.addr == s.vbr + 32'({s.src, 2'b00})
	) else $error("Vector read at wrong table entry");

	AST_IRQ_CAUSE: assert property (
		|s.irq |-> $past(s.st) == S_XWR && $past(mdone)
	) else $error("Processor interrupt without a finished unit");

	AST_STOP_HOLDS: assert property (
		s.st == S_IDLE && s.ctrl[ETTE_CTRL_STOP] |=> s.st == S_IDLE
	) else $error("Engine started while stopped");

	AST_SIZE: assert property (
		s.mreq.valid && (s.st == S_XRD || s.st == S_XWR) |->
			s.mreq.size == s.mode[ETTE_SZ_LO +: 2]
	) else $error("Datum size differs from descriptor");

	AST_NORMAL_CNT: assert property (
		s.st == S_XWR && mdone && s.mode[ETTE_MD_LO +: 2] == ETTE_MD_NORMAL |=>
			s.cnt[15:0] == $past(s.cnt[15:0]) - 16'h0001
	) else $error("Normal count not decremented by one");

	AST_APB_ANSWER: assert property (
		psel && !penable |=> pready ##1 !pready || (psel && !penable)
	) else $error("Register access not answered in one cycle");

	AST_NO_IRQ_EARLY: assert property (
		s.st == S_XWR && mdone && !s.mode[ETTE_DISEL] &&
			s.mode[ETTE_MD_LO +: 2] == ETTE_MD_NORMAL && s.cnt[15:0] != 16'h0001 |=> !(|s.irq)
	) else $error("Interrupt raised before count exhausted");

	CV_CHAIN: cover property (s.st == S_DWB && s.chained ##[1:40] s.st == S_IDLE);
	CV_SKIP: cover property (s.st == S_IDLE ##1 s.st == S_XRD);
	CV_BLOCK: cover property (s.st == S_XWR && s.mode[ETTE_MD_LO +: 2] == ETTE_MD_BLOCK && |n.irq);
	CV_GAP: cover property (s.st == S_GAP);

endmodule

/* verification/ette_mem_model.sv */
`timescale 1ns/10ps
// Memory and peripheral space seen by the engine's bus port
module ette_mem_model import ette_pkg::*; (
	input  wire logic       pclk,
	input  wire logic       slow,
	input  wire ette_mreq_t mreq,
	output      ette_mrsp_t mrsp
);
	logic [31:0] mem [0:4095];
	logic [31:0] last;
	logic [3:0]  wcnt;

	initial begin
		wcnt = 4'h0;
		last = 32'h0000_0000;
	end

	// Slow mode stalls each access for three cycles
	always_comb begin
		mrsp.ready = mreq.valid && (wcnt >= (slow ? 4'h3 : 4'h0));
		// Idle data bus shows the inverse, never a stale match
		mrsp.rdata = mrsp.ready ? mem[mreq.addr[11:0]] : ~last;
	end

	always @(posedge pclk) begin
		wcnt <= (mreq.valid && !mrsp.ready) ? wcnt + 4'h1 : 4'h0;
		if (mrsp.ready) begin
			last <= mrsp.rdata;
			if (mreq.write)
				mem[mreq.addr[11:0]] <= mreq.wdata;
		end
	end
endmodule

/* verification/event_triggered_transfer_engine_bench.sv */
`timescale 1ns/10ps
module event_triggered_transfer_engine_bench import ette_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, er;
	logic [7:0]  paddr, act_req, cpu_irq;
	logic [31:0] pwdata, prdata, rd;
	ette_mreq_t  mreq;
	ette_mrsp_t  mrsp;
	int          num_errors, checked, cyc;
	int          irqs [8];

	ette_top #(.NSRC(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mreq(mreq),
		.mrsp(mrsp), .act_req(act_req), .cpu_irq(cpu_irq));
	ette_mem_model M (.pclk(pclk), .slow(slow), .mreq(mreq), .mrsp(mrsp));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		for (int k = 0; k < 8; k++)
			if (cpu_irq[k] === 1'b1)
				irqs[k]++;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse(input logic [7:0] m);
		@(posedge pclk);
		act_req <= m;
		@(posedge pclk);
		act_req <= 8'h00;
	endtask

	// Poll status until nothing is busy or pending
	task automatic wait_idle();
		do apb(1'b0, ETTE_OFS_STAT, 32'h0); while (rd[0] !== 1'b0 || rd[12:5] !== 8'h00);
	endtask

	// One activation, then wait for the engine to settle
	task automatic fire(input int s);
		pulse(8'(1 << s));
		wait_idle();
	endtask

	task automatic setd(input int s, input int d, input logic [31:0] md, sa, da, cn);
		M.mem[12'h100 + 4 * s] = d;
		M.mem[d] = md;
		M.mem[d + 4] = sa;
		M.mem[d + 8] = da;
		M.mem[d + 12] = cn;
	endtask

	initial begin
		{presetn, psel, penable, pwrite, slow} = 5'h00;
		{paddr, act_req, pwdata, num_errors, checked, cyc} = '0;
		for (int k = 0; k < 8; k++)
			irqs[k] = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, 8'(4 * k), 32'h0);
			chk("reset value", rd, 32'h0);
		end
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped error", {31'h0, er}, 32'h1);
		apb(1'b1, ETTE_OFS_VBR, 32'h0000_0100);
		apb(1'b1, ETTE_OFS_ENA, 32'h0000_001e);
		// Transmit channel, cycling every release policy and every option bit except stop
		setd(1, 'h200, 32'h20, 32'h400, 32'h800, 32'd32);
		for (int i = 0; i < 32; i++) begin
			M.mem[12'h400 + i] = 32'h40 + i;
			apb(1'b1, ETTE_OFS_CTRL, ((i % 5) << 4) | ((i & 1) << 3)
				| ((i % 3 == 0) << 2) | (i >= 16));
			fire(1);
			chk("tx byte", {24'h0, M.mem[12'h800][7:0]}, 32'h40 + i);
		end
		chk("tx source wb", M.mem[12'h204], 32'h420);
		chk("tx dest wb", M.mem[12'h208], 32'h800);
		chk("tx count wb", {16'h0, M.mem[12'h20c][15:0]}, 32'h0);
		chk("tx irq once", irqs[1], 32'd1);
		apb(1'b0, ETTE_OFS_ENA, 32'h0);
		chk("tx enable clear", rd, 32'h1c);
		apb(1'b1, ETTE_OFS_CTRL, 32'h0);
		// Receive channel with a slow far side and an interrupt per unit
		slow <= 1'b1;
		setd(2, 'h300, 32'h280, 32'h900, 32'h500, 32'd4);
		for (int i = 0; i < 4; i++) begin
			M.mem[12'h900] = 32'h70 + i;
			fire(2);
			chk("rx byte", {24'h0, M.mem[12'h500 + i][7:0]}, 32'h70 + i);
			chk("rx irq", irqs[2], i + 1);
		end
		chk("rx dest wb", M.mem[12'h308], 32'h504);
		slow <= 1'b0;
		// Block of two words chained to one longword move
		setd(3, 'h600, 32'h1a6, 32'ha00, 32'hb00, 32'h0001_0002);
		setd(5, 'h610, 32'hc8, 32'hc00, 32'hd00, 32'h1);
		M.mem[12'ha00] = 32'h1234;
		M.mem[12'ha02] = 32'h5678;
		M.mem[12'hc00] = 32'hcafe_0001;
		fire(3);
		chk("block word 0", {16'h0, M.mem[12'hb00][15:0]}, 32'h1234);
		chk("block word 1", {16'h0, M.mem[12'hb02][15:0]}, 32'h5678);
		chk("chain long", M.mem[12'hd00], 32'hcafe_0001);
		chk("chain dest wb", M.mem[12'h618], 32'hcfc);
		chk("block source wb", M.mem[12'h604], 32'ha04);
		chk("block count wb", {16'h0, M.mem[12'h60c][31:16]}, 32'h0);
		// Repeat mode reloads its count and never completes
		setd(4, 'h700, 32'h21, 32'he00, 32'he80, 32'h0000_0202);
		fire(4);
		fire(4);
		chk("repeat reload", {24'h0, M.mem[12'h70c][7:0]}, 32'h2);
		chk("repeat no irq", irqs[4], 32'd0);
		// Stopped unit keeps requests pending; lowest source goes first
		setd(6, 32'h0000_0740, 32'h21, 32'he10, 32'he90, 32'h0000_0202);
		apb(1'b1, ETTE_OFS_ENA, 32'h0000_0050);
		apb(1'b1, ETTE_OFS_CTRL, 32'h0000_0002);
		pulse(8'h50);
		repeat (3) @(posedge pclk);
		apb(1'b0, ETTE_OFS_STAT, 32'h0);
		chk("stop pending", 32'({rd[12:5], rd[0]}), 32'ha0);
		apb(1'b1, ETTE_OFS_CTRL, 32'h0);
		wait_idle();
		chk("fixed priority", 32'(rd[4:2]), 32'h6);
		chk("stopped unit ran", {24'h0, M.mem[12'h70c][7:0]}, 32'h1);
		chk("second source ran", {24'h0, M.mem[12'h74c][7:0]}, 32'h1);
		test_done();
	end
endmodule
